// ---- design/async_serial_adapter.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "serial_adapter_cfg.svh"

module async_serial_adapter #(
  parameter int BIT_CLK_DIV = `SA_BIT_CLK_DIV,
  parameter int FIFO_DEPTH = `SA_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_resetn,
  // Host port
  input wire serial_adapter_pkg::host_req_s i_host,
  output logic [7:0] o_rdata,
  output logic o_irq_n,
  // Serial line and modem pins
  input wire logic i_rx_data,
  input wire logic i_carrier_n,
  output logic o_tx_data,
  output logic o_send_req_n
);

  // Format decode shared by both directions
  function automatic logic fmt_word8(input logic [2:0] f);
    return f[2];
  endfunction : fmt_word8

  function automatic logic fmt_parity(input logic [2:0] f);
    return !(f[2] && !f[1]);
  endfunction : fmt_parity

  function automatic logic fmt_odd(input logic [2:0] f);
    return f[0];
  endfunction : fmt_odd

  function automatic logic fmt_two_stop(input logic [2:0] f);
    return (f[2:1] == 2'h0) || (f == 3'h4);
  endfunction : fmt_two_stop

  function automatic logic [3:0] fmt_bits(input logic [2:0] f);
    return (fmt_word8(f) ? 4'h8 : 4'h7) + {3'h0, fmt_parity(f)};
  endfunction : fmt_bits

  // Control register and host decode
  logic [7:0] ctrl_q;
  wire [1:0] div_sel = ctrl_q[`SA_CTRL_DIV_HI:`SA_CTRL_DIV_LO];
  wire [2:0] fmt = ctrl_q[`SA_CTRL_FMT_HI:`SA_CTRL_FMT_LO];
  wire [1:0] txc = ctrl_q[`SA_CTRL_TXC_HI:`SA_CTRL_TXC_LO];
  wire mreset = (div_sel == `SA_DIV_MRESET);
  wire [6:0] ratio = (div_sel == `SA_DIV_64) ? `SA_RATIO_64 :
                     (div_sel == `SA_DIV_16) ? `SA_RATIO_16 : `SA_RATIO_1;
  wire [6:0] half = {1'b0, ratio[6:1]};
  wire send_break = (txc == `SA_TXC_BREAK);

  wire ctrl_wr = i_host.sel && i_host.wr && (i_host.reg_sel == `SA_SEL_CTRL_STATUS);
  wire tx_wr = i_host.sel && i_host.wr && (i_host.reg_sel == `SA_SEL_DATA);
  wire stat_rd = i_host.sel && i_host.rd && (i_host.reg_sel == `SA_SEL_CTRL_STATUS);
  wire rx_rd = i_host.sel && i_host.rd && (i_host.reg_sel == `SA_SEL_DATA);

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      ctrl_q <= `SA_CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_q <= i_host.wdata;
    end
  end

  // Pin synchronisers
  logic rx_s1_q;
  logic rx_s2_q;
  logic dcd_s1_q;
  logic dcd_s2_q;

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
      dcd_s1_q <= 1'b1;
      dcd_s2_q <= 1'b1;
    end else begin
      rx_s1_q <= i_rx_data;
      rx_s2_q <= rx_s1_q;
      dcd_s1_q <= i_carrier_n;
      dcd_s2_q <= dcd_s1_q;
    end
  end

  // Serial clock enable from the prescaler
  logic [15:0] pre_q;
  wire tick = (pre_q == 16'(BIT_CLK_DIV - 1));

  always_ff @(posedge i_clock) begin
    if (!i_resetn || tick) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + 16'h0001;
    end
  end

  // Transmit path through the FIFO
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic [11:0] tx_shift_q;
  logic [3:0] tx_left_q;
  logic [6:0] tx_cnt_q;
  logic txd_q;
  logic rts_n_q;

  wire tx_idle = (tx_left_q == 4'h0);
  // Shifter stalls the FIFO while busy or sending break, so it really fills
  wire tx_load = tx_idle && fifo_out_valid && !mreset && !send_break;
  wire tx_bit_end = tick && !tx_idle && (tx_cnt_q == ratio - 7'h01);
  wire [7:0] tx_char = fmt_word8(fmt) ? fifo_out_data : {1'b0, fifo_out_data[6:0]};
  wire tx_par = (^tx_char) ^ fmt_odd(fmt);
  wire [3:0] tx_len = 4'h2 + fmt_bits(fmt) + {3'h0, fmt_two_stop(fmt)};
  // Start low, data LSB first, parity, then high stops
  wire [11:0] tx_frame = fmt_word8(fmt) ?
      (fmt_parity(fmt) ? {2'h3, tx_par, tx_char, 1'b0} : {3'h7, tx_char, 1'b0}) :
      {3'h7, tx_par, tx_char[6:0], 1'b0};

  tx_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_flush(mreset),
    .i_in_valid(tx_wr),
    .o_in_ready(fifo_in_ready),
    .i_in_data(i_host.wdata),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(tx_load),
    .o_out_data(fifo_out_data)
  );

  always_ff @(posedge i_clock) begin
    if (!i_resetn || mreset) begin
      tx_shift_q <= 12'hFFF;
      tx_left_q <= 4'h0;
      tx_cnt_q <= 7'h00;
    end else if (tx_load) begin
      tx_shift_q <= tx_frame;
      tx_left_q <= tx_len;
      tx_cnt_q <= 7'h00;
    end else if (tx_bit_end) begin
      tx_shift_q <= {1'b1, tx_shift_q[11:1]};
      tx_left_q <= tx_left_q - 4'h1;
      tx_cnt_q <= 7'h00;
    end else if (tick && !tx_idle) begin
      tx_cnt_q <= tx_cnt_q + 7'h01;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      txd_q <= 1'b1;
      rts_n_q <= 1'b1;
    end else begin
      txd_q <= send_break ? 1'b0 : (tx_idle ? 1'b1 : tx_shift_q[0]);
      rts_n_q <= mreset || (txc == `SA_TXC_RTS_HIGH);
    end
  end

  // Receiver
  serial_adapter_pkg::rx_state_e rx_state_q;
  logic [6:0] rx_cnt_q;
  logic [3:0] rx_idx_q;
  logic [8:0] rx_bits_q;
  logic rx_done_q;
  logic rx_ferr_q;

  wire rx_bit_end = tick && (rx_cnt_q == ratio - 7'h01);

  always_ff @(posedge i_clock) begin
    if (!i_resetn || mreset) begin
      rx_state_q <= serial_adapter_pkg::RX_IDLE;
      rx_cnt_q <= 7'h00;
      rx_idx_q <= 4'h0;
      rx_bits_q <= 9'h000;
      rx_done_q <= 1'b0;
      rx_ferr_q <= 1'b0;
    end else begin
      rx_done_q <= 1'b0;
      case (rx_state_q)
        serial_adapter_pkg::RX_IDLE: begin
          rx_cnt_q <= 7'h00;
          if (tick && !rx_s2_q) begin
            rx_state_q <= serial_adapter_pkg::RX_START;
          end
        end
        serial_adapter_pkg::RX_START: begin
          // Recheck mid start bit to reject glitches
          if (tick && rx_cnt_q == half) begin
            rx_cnt_q <= 7'h00;
            rx_idx_q <= 4'h0;
            rx_state_q <= rx_s2_q ? serial_adapter_pkg::RX_IDLE : serial_adapter_pkg::RX_DATA;
          end else if (tick) begin
            rx_cnt_q <= rx_cnt_q + 7'h01;
          end
        end
        serial_adapter_pkg::RX_DATA: begin
          if (rx_bit_end) begin
            rx_cnt_q <= 7'h00;
            rx_bits_q[rx_idx_q] <= rx_s2_q;
            rx_idx_q <= rx_idx_q + 4'h1;
            if (rx_idx_q == fmt_bits(fmt) - 4'h1) begin
              rx_state_q <= serial_adapter_pkg::RX_STOP;
            end
          end else if (tick) begin
            rx_cnt_q <= rx_cnt_q + 7'h01;
          end
        end
        serial_adapter_pkg::RX_STOP: begin
          // Only the first stop is checked; a second one looks like idle
          if (rx_bit_end) begin
            rx_done_q <= 1'b1;
            rx_ferr_q <= !rx_s2_q;
            rx_state_q <= serial_adapter_pkg::RX_IDLE;
          end else if (tick) begin
            rx_cnt_q <= rx_cnt_q + 7'h01;
          end
        end
        default: begin
          rx_state_q <= serial_adapter_pkg::RX_IDLE;
        end
      endcase
    end
  end

  wire [7:0] rx_char = fmt_word8(fmt) ? rx_bits_q[7:0] : {1'b0, rx_bits_q[6:0]};
  wire rx_pbit = fmt_word8(fmt) ? rx_bits_q[8] : rx_bits_q[7];
  wire rx_perr = fmt_parity(fmt) && (((^rx_char) ^ rx_pbit) != fmt_odd(fmt));

  // Receive holding and status flags
  logic [7:0] rx_hold_q;
  logic rx_full_q;
  logic overrun_q;
  logic ferr_q;
  logic perr_q;
  logic irq_q;
  logic [7:0] rdata_q;

  // A read in the same cycle frees the holding register for the new character
  wire rx_load = rx_done_q && (!rx_full_q || rx_rd);
  wire rx_lost = rx_done_q && rx_full_q && !rx_rd;
  wire rx_full_d = rx_load || (rx_full_q && !rx_rd);
  wire overrun_d = rx_lost || (overrun_q && !rx_rd);
  wire tx_empty = fifo_in_ready;
  wire rx_irq = ctrl_q[`SA_CTRL_RXIE] && (rx_full_d || overrun_d);
  wire tx_irq = (txc == `SA_TXC_TIE) && tx_empty && !tx_wr;
  wire irq_d = !mreset && (rx_irq || tx_irq);

  serial_adapter_pkg::line_status_s status;
  assign status.irq = irq_q;
  assign status.parity_err = perr_q;
  assign status.overrun = overrun_q;
  assign status.framing_err = ferr_q;
  assign status.clear_to_send = 1'b0;
  assign status.no_carrier = dcd_s2_q;
  assign status.tx_holding_empty = tx_empty && !mreset;
  assign status.rx_holding_full = rx_full_q;

  always_ff @(posedge i_clock) begin
    if (!i_resetn || mreset) begin
      rx_hold_q <= 8'h00;
      rx_full_q <= 1'b0;
      overrun_q <= 1'b0;
      ferr_q <= 1'b0;
      perr_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      rx_full_q <= rx_full_d;
      overrun_q <= overrun_d;
      irq_q <= irq_d;
      if (rx_load) begin
        rx_hold_q <= rx_char;
        ferr_q <= rx_ferr_q;
        perr_q <= rx_perr;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      rdata_q <= 8'h00;
    end else if (stat_rd) begin
      rdata_q <= status;
    end else if (rx_rd) begin
      rdata_q <= rx_hold_q;
    end
  end

  assign o_rdata = rdata_q;
  assign o_irq_n = !irq_q;
  assign o_tx_data = txd_q;
  assign o_send_req_n = rts_n_q;

endmodule : async_serial_adapter

`default_nettype wire

// ---- design/serial_adapter_cfg.svh ----
// How it works
// - Control bits 1:0: divide 1/16/64 or reset
// - Control bits 4:2 pick length, parity, stops
// - Control bits 6:5: send-request, tx interrupt, break
// - Control bit 7 enables receive interrupts
// - Transmission starts within one bit period
// - Status bit 1 set while the transmit FIFO has room
// - Completed character fills empty holding, sets bit0
// - Receive-full clears on read or master reset
// - Status bit 2 shows carrier absent
// - Status bit 4 flags missing first stop
// - Status bit 5 flags lost characters
// - Status bit 6 flags parity mismatch
// - Status bit 7 mirrors interrupt request output
// - Interrupt bit clears on data read; tx interrupt drops while FIFO is full and for one cycle after each data write
// - Two locations: write control/tx, read status/rx
`ifndef SERIAL_ADAPTER_CFG_SVH
`define SERIAL_ADAPTER_CFG_SVH

// Register select values
`define SA_SEL_CTRL_STATUS 1'b0
`define SA_SEL_DATA 1'b1

// Control register fields and reset value
`define SA_CTRL_RESET 8'h03
`define SA_CTRL_DIV_HI 1
`define SA_CTRL_DIV_LO 0
`define SA_CTRL_FMT_HI 4
`define SA_CTRL_FMT_LO 2
`define SA_CTRL_TXC_HI 6
`define SA_CTRL_TXC_LO 5
`define SA_CTRL_RXIE 7

// Divide codes
`define SA_DIV_1 2'h0
`define SA_DIV_16 2'h1
`define SA_DIV_64 2'h2
`define SA_DIV_MRESET 2'h3
`define SA_RATIO_1 7'h01
`define SA_RATIO_16 7'h10
`define SA_RATIO_64 7'h40

// Transmitter control codes
`define SA_TXC_TIE 2'h1
`define SA_TXC_RTS_HIGH 2'h2
`define SA_TXC_BREAK 2'h3

// Input clock to serial clock prescale, cycles
`define SA_BIT_CLK_DIV 16
`define SA_FIFO_DEPTH 16

`endif

// ---- design/serial_adapter_pkg.sv ----
package serial_adapter_pkg;

  // One host bus cycle, strobes valid for one clock
  typedef struct packed {
    logic sel;
    logic reg_sel;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } host_req_s;

  typedef struct packed {
    logic irq;
    logic parity_err;
    logic overrun;
    logic framing_err;
    logic clear_to_send;
    logic no_carrier;
    logic tx_holding_empty;
    logic rx_holding_full;
  } line_status_s;

  typedef enum logic [3:0] {
    RX_IDLE = 4'h1,
    RX_START = 4'h2,
    RX_DATA = 4'h4,
    RX_STOP = 4'h8
  } rx_state_e;

endpackage : serial_adapter_pkg

// ---- design/tx_fifo.sv ----
`timescale 1ns/100ps
`default_nettype none

module tx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_flush,
  // Fill side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  // Drain side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  logic out_valid_q;
  logic [WIDTH-1:0] out_data_q;

  wire push = i_in_valid && o_in_ready;
  // Output register is refilled whenever it empties or is taken
  wire load = (count_q != '0) && (!out_valid_q || i_out_ready);
  wire take = out_valid_q && i_out_ready;

  assign o_in_ready = (count_q != (AW+1)'(DEPTH)) && !i_flush;
  assign o_out_valid = out_valid_q;
  assign o_out_data = out_data_q;

  always_ff @(posedge i_clock) begin
    if (push) begin
      mem_q[wr_ptr_q] <= i_in_data;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_resetn || i_flush) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
      out_valid_q <= 1'b0;
      out_data_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (load) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
        out_data_q <= mem_q[rd_ptr_q];
        out_valid_q <= 1'b1;
      end else if (take) begin
        out_valid_q <= 1'b0;
      end
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(load);
    end
  end

endmodule : tx_fifo

`default_nettype wire

// ---- test/async_serial_adapter_monitor.sv ----
`timescale 1ns/100ps
`default_nettype none

module async_serial_adapter_monitor #(
  parameter int BIT_CLK_DIV = 16
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_resetn,
  // Watched ports
  input wire serial_adapter_pkg::host_req_s i_host,
  input wire logic [7:0] o_rdata,
  input wire logic o_irq_n,
  input wire logic i_carrier_n,
  input wire logic o_tx_data,
  input wire logic o_send_req_n
);
  localparam int TMAX = 16 * BIT_CLK_DIV + 5;
  localparam int IDLE = 48 * BIT_CLK_DIV;
  logic [7:0] ctrl_q;
  logic [15:0] idle_q;
  wire logic rd_st = i_host.sel && i_host.rd && !i_host.reg_sel;
  wire logic rd_rx = i_host.sel && i_host.rd && i_host.reg_sel;
  wire logic wr_tx = i_host.sel && i_host.wr && i_host.reg_sel;
  wire logic wr_ct = i_host.sel && i_host.wr && !i_host.reg_sel;
  wire logic mr = ctrl_q[1:0] == 2'h3;
  wire logic [1:0] txc = ctrl_q[6:5];

  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_resetn);

  // Long idle means nothing is queued, so a write must start a frame
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      ctrl_q <= 8'h03;
      idle_q <= 16'h0000;
    end else begin
      if (wr_ct) ctrl_q <= i_host.wdata;
      if (!o_tx_data) idle_q <= 16'h0000;
      else if (idle_q != 16'hFFFF) idle_q <= idle_q + 16'h0001;
    end
  end

  chk_mreset_quiet: assert property (mr && $past(mr) |-> o_tx_data && o_irq_n)
    else $error("line or irq active in master reset");
  chk_send_req: assert property ($stable(ctrl_q) |-> o_send_req_n == (txc == 2'h2 || mr))
    else $error("send request level wrong");
  chk_break_low: assert property ($stable(ctrl_q) && txc == 2'h3 && !mr |-> !o_tx_data)
    else $error("break not sent");
  chk_irq_mirror: assert property (rd_st |=> o_rdata[7] == !$past(o_irq_n))
    else $error("status irq bit differs");
  chk_carrier_bit: assert property (i_carrier_n [*6] ##0 rd_st |=> o_rdata[2])
    else $error("no carrier not shown");
  chk_tx_start: assert property (wr_tx && idle_q > IDLE && ctrl_q[1:0] == 2'h1 && txc != 2'h3
    |-> ##[1:TMAX] !o_tx_data)
    else $error("frame did not start in time");
  chk_irq_masked: assert property ($stable(ctrl_q) && !ctrl_q[7] && txc != 2'h1 |-> o_irq_n)
    else $error("irq while disabled");
  chk_rdata_hold: assert property (!(i_host.sel && i_host.rd) |=> $stable(o_rdata))
    else $error("read data changed without read");
  chk_seven_msb: assert property (rd_rx && !ctrl_q[4] |=> !o_rdata[7])
    else $error("seven bit char has msb set");
endmodule : async_serial_adapter_monitor

bind async_serial_adapter async_serial_adapter_monitor #(.BIT_CLK_DIV(BIT_CLK_DIV))
  async_serial_adapter_monitor_i (.i_clock(i_clock), .i_resetn(i_resetn), .i_host(i_host),
  .o_rdata(o_rdata), .o_irq_n(o_irq_n), .i_carrier_n(i_carrier_n), .o_tx_data(o_tx_data),
  .o_send_req_n(o_send_req_n));

`default_nettype wire

// ---- test/async_serial_adapter_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
  $display("wrong value at %0t: %h vs %h", $time, (g), (e)); end end

module async_serial_adapter_tb;
  logic i_clock = 1'b0;
  logic i_resetn = 1'b0;
  serial_adapter_pkg::host_req_s host = '0;
  logic [7:0] rdata;
  logic irq_n;
  logic rx;
  logic car_n;
  logic tx;
  logic rts_n;
  logic [9:0] fv;
  int err_count = 0;
  int num_checks = 0;

  always #2.5 i_clock = ~i_clock;

  async_serial_adapter #(.BIT_CLK_DIV(2), .FIFO_DEPTH(16)) async_serial_adapter_i (
    .i_clock(i_clock), .i_resetn(i_resetn), .i_host(host), .o_rdata(rdata),
    .o_irq_n(irq_n), .i_rx_data(rx), .i_carrier_n(car_n), .o_tx_data(tx),
    .o_send_req_n(rts_n));
  serial_peer serial_peer_i (.i_clock(i_clock), .i_tx_data(tx), .o_rx_data(rx),
    .o_carrier_n(car_n));

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize

  // One strobe cycle, then a quiet cycle so read data has landed
  task automatic acc(input logic rs, input logic w, input logic [7:0] wd);
    host = {1'b1, rs, !w, w, wd};
    @(negedge i_clock);
    host = '0;
    @(negedge i_clock);
  endtask : acc

  function automatic logic [9:0] fr(input logic [7:0] d, input logic [2:0] f);
    logic [9:0] v = 10'h3FE;
    int n = f[2] ? 8 : 7;
    for (int i = 0; i < n; i++) v[i+1] = d[i];
    if (f[2:1] != 2'h2) v[n+1] = ^(f[2] ? d : {1'b0, d[6:0]}) ^ f[0];
    return v;
  endfunction : fr

  task automatic wait_full();
    int n = 0;
    acc(1'b0, 1'b0, 8'h00);
    while (rdata[0] !== 1'b1) begin
      if (++n > 400) begin
        err_count++;
        summarize();
      end
      acc(1'b0, 1'b0, 8'h00);
    end
  endtask : wait_full

  task automatic wait_tx(input int cnt);
    int n = 0;
    while (serial_peer_i.frames.size() < cnt) begin
      if (++n > 8000) begin
        err_count++;
        summarize();
      end
      @(negedge i_clock);
    end
  endtask : wait_tx

  task automatic t_reset();
    acc(1'b0, 1'b1, 8'h03);
    acc(1'b0, 1'b0, 8'h00);
    `CHK(rdata[0], 1'b0)
    acc(1'b0, 1'b1, 8'h15);
    acc(1'b0, 1'b0, 8'h00);
    `CHK(rdata, 8'h02)
    `CHK(rts_n, 1'b0)
    serial_peer_i.o_carrier_n = 1'b1;
    repeat (8) @(negedge i_clock);
    acc(1'b0, 1'b0, 8'h00);
    `CHK(rdata, 8'h06)
    serial_peer_i.o_carrier_n = 1'b0;
    $display("t_reset done");
  endtask : t_reset

  task automatic t_tx_fmt();
    for (int f = 0; f < 8; f++) begin
      acc(1'b0, 1'b1, {3'h0, f[2:0], 2'h1});
      acc(1'b1, 1'b1, 8'hB6);
      wait_tx(1);
      fv = serial_peer_i.frames.pop_front();
      `CHK(fv, fr(8'hB6, f[2:0]))
      repeat (160) @(negedge i_clock);
    end
    $display("t_tx_fmt done");
  endtask : t_tx_fmt

  task automatic t_rx_fmt();
    for (int f = 0; f < 8; f++) begin
      acc(1'b0, 1'b1, {3'h0, f[2:0], 2'h1});
      serial_peer_i.send(fr(8'hC5, f[2:0]));
      wait_full();
      `CHK(rdata, 8'h03)
      acc(1'b1, 1'b0, 8'h00);
      `CHK(rdata, f[2] ? 8'hC5 : 8'h45)
      acc(1'b0, 1'b0, 8'h00);
      `CHK(rdata, 8'h02)
    end
    $display("t_rx_fmt done");
  endtask : t_rx_fmt

  task automatic t_rx_err();
    acc(1'b0, 1'b1, 8'h09);
    serial_peer_i.send(fr(8'h5A, 3'h2) ^ 10'h100);
    wait_full();
    `CHK(rdata, 8'h43)
    acc(1'b1, 1'b0, 8'h00);
    acc(1'b0, 1'b1, 8'h15);
    serial_peer_i.send(fr(8'h5A, 3'h5) ^ 10'h200);
    wait_full();
    `CHK(rdata, 8'h13)
    acc(1'b1, 1'b0, 8'h00);
    $display("t_rx_err done");
  endtask : t_rx_err

  task automatic t_overrun();
    serial_peer_i.send(fr(8'h11, 3'h5));
    serial_peer_i.send(fr(8'h22, 3'h5));
    repeat (64) @(negedge i_clock);
    acc(1'b0, 1'b0, 8'h00);
    `CHK(rdata, 8'h23)
    acc(1'b1, 1'b0, 8'h00);
    `CHK(rdata, 8'h11)
    acc(1'b0, 1'b0, 8'h00);
    `CHK(rdata, 8'h02)
    $display("t_overrun done");
  endtask : t_overrun

  task automatic t_irq();
    acc(1'b0, 1'b1, 8'h95);
    `CHK(irq_n, 1'b1)
    serial_peer_i.send(fr(8'h33, 3'h5));
    wait_full();
    `CHK(rdata, 8'h83)
    `CHK(irq_n, 1'b0)
    acc(1'b1, 1'b0, 8'h00);
    `CHK(irq_n, 1'b1)
    acc(1'b0, 1'b1, 8'h35);
    `CHK(irq_n, 1'b0)
    acc(1'b0, 1'b1, 8'h15);
    `CHK(irq_n, 1'b1)
    $display("t_irq done");
  endtask : t_irq

  // Shifter plus queue hold the accepted bytes; the rest are dropped
  task automatic t_fifo();
    int n;
    for (int i = 0; i < 20; i++) acc(1'b1, 1'b1, 8'h40 + i[7:0]);
    acc(1'b0, 1'b0, 8'h00);
    `CHK(rdata[1], 1'b0)
    wait_tx(17);
    repeat (700) @(negedge i_clock);
    n = serial_peer_i.frames.size();
    `CHK(n >= 17 && n <= 18, 1'b1)
    for (int i = 0; i < 17; i++) begin
      fv = serial_peer_i.frames.pop_front();
      `CHK(fv, fr(8'h40 + i[7:0], 3'h5))
    end
    serial_peer_i.frames.delete();
    acc(1'b0, 1'b0, 8'h00);
    `CHK(rdata[1], 1'b1)
    $display("t_fifo done");
  endtask : t_fifo

  task automatic t_div();
    logic [7:0] c[2] = '{8'h14, 8'h16};
    int w[2] = '{2, 128};
    for (int k = 0; k < 2; k++) begin
      serial_peer_i.bitw = w[k];
      acc(1'b0, 1'b1, c[k]);
      acc(1'b1, 1'b1, 8'h9C);
      wait_tx(1);
      fv = serial_peer_i.frames.pop_front();
      `CHK(fv, fr(8'h9C, 3'h5))
      repeat (300) @(negedge i_clock);
    end
    serial_peer_i.bitw = 32;
    $display("t_div done");
  endtask : t_div

  task automatic t_break();
    acc(1'b0, 1'b1, 8'h75);
    repeat (4) @(negedge i_clock);
    `CHK({tx, rts_n}, 2'h0)
    acc(1'b0, 1'b1, 8'h55);
    repeat (4) @(negedge i_clock);
    `CHK({tx, rts_n}, 2'h3)
    acc(1'b0, 1'b1, 8'h03);
    `CHK({tx, rts_n, irq_n}, 3'h7)
    repeat (400) @(negedge i_clock);
    serial_peer_i.frames.delete();
    $display("t_break done");
  endtask : t_break

  initial begin
    repeat (16) @(negedge i_clock);
    i_resetn = 1'b1;
    t_reset();
    t_tx_fmt();
    t_rx_fmt();
    t_rx_err();
    t_overrun();
    t_irq();
    t_fifo();
    t_div();
    t_break();
    summarize();
  end
endmodule : async_serial_adapter_tb

`default_nettype wire

// ---- test/serial_peer.sv ----
`timescale 1ns/100ps
`default_nettype none

module serial_peer (
  // Clock
  input wire logic i_clock,
  // Line from the adapter
  input wire logic i_tx_data,
  // Lines to the adapter
  output logic o_rx_data,
  output logic o_carrier_n
);
  int bitw = 32;
  logic [9:0] frame;
  logic [9:0] frames[$];

  initial begin
    o_rx_data = 1'b1;
    o_carrier_n = 1'b0;
  end

  // Caller starts on a falling edge; line left idle high
  task automatic send(input logic [9:0] v);
    for (int i = 0; i < 10; i++) begin
      o_rx_data = v[i];
      repeat (bitw) @(negedge i_clock);
    end
    o_rx_data = 1'b1;
  endtask : send

  // Only ten bits are kept, so the stop bit of 8-bit parity frames is not captured
  always begin
    @(negedge i_tx_data);
    repeat (bitw / 2) @(negedge i_clock);
    for (int i = 0; i < 10; i++) begin
      if (i > 0) repeat (bitw) @(negedge i_clock);
      frame[i] = i_tx_data;
    end
    frames.push_back(frame);
  end
endmodule : serial_peer

`default_nettype wire
